// ---- sfic_assertions.sv ----
// concurrent checks on the serial link and flash state
`timescale 1ns/10ps
module sfic_assertions
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic miso_oe_n,
  // flash state
  input wire logic reset_cmd_enable,
  input wire logic write_enable_latch,
  input wire logic deep_powerdown,
  input wire logic standby
);
  logic [11:0] cs_high_reg;
  logic [11:0] cs_high_next;
  // cycles since deselect, saturating
  assign cs_high_next = !cs_n ? 12'h000 :
                        (cs_high_reg == 12'hfff) ? cs_high_reg : cs_high_reg + 12'h001;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cs_high_reg <= 12'h000;
    else
      cs_high_reg <= cs_high_next;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence frame_end_s;
    $rose(cs_n);
  endsequence
  sequence resume_done_s;
    $rose(standby) ##0 (cs_high_reg > 12'd100);
  endsequence
  idle_clock_low_a: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  output_release_a: assert property (frame_end_s |-> ##[1:3] miso_oe_n)
    else $error("output still driven after deselect");
  drive_in_frame_a: assert property ($fell(miso_oe_n) |-> !cs_n)
    else $error("output driven outside a frame");
  enable_change_a: assert property ($changed(reset_cmd_enable) |-> cs_n && !write_enable_latch)
    else $error("enable bit changed outside a status write");
  latch_clear_a: assert property ($fell(write_enable_latch) |-> cs_n)
    else $error("write latch cleared inside a frame");
  deep_quiet_a: assert property (deep_powerdown |-> miso_oe_n && !standby)
    else $error("activity during deep power-down");
  deep_latch_a: assert property ($rose(write_enable_latch) |-> !deep_powerdown)
    else $error("write latch set in deep power-down");
  entry_time_a: assert property ($rose(deep_powerdown) |-> cs_high_reg inside {[12'd746:12'd758]})
    else $error("deep power-down entry time wrong");
  standby_time_a: assert property ($rose(standby) |-> (cs_high_reg < 12'd8) or resume_done_s)
    else $error("standby reached at wrong time");
  resume_time_a: assert property (resume_done_s |-> cs_high_reg inside {[12'd1996:12'd2010]})
    else $error("resume time wrong");
endmodule

// ---- sfic_flash.sv ----
// flash-side command logic: status byte two, id reads, deep power-down
// Operation
// - host sets write latch before status write
// - opcode 31h plus one byte, bit 4 only
// - bytes after the data byte are discarded
// - valid write updates enable bit, clears latch
// - short or misaligned write aborts, latch cleared
// - only that write changes enable bit
// - 9Fh returns maker, two id, zero length
// - after length byte output released, clocks ignored
// - chip select rise ends standard id read
// - 15h returns maker and device code
// - chip select rise ends legacy id read
// - deselected and idle means standby
// - B9h then deselect enters deep power-down
// - bad deep power-down command stays in standby
// - deep power-down ignores all but resume
// - deep power-down ignored while busy
// - ABh then deselect returns to standby
// - bad resume stays in deep power-down
// - start in standby after power-up
// - host reads ids at low clock rate
// - enable bit resets low, reset command blocked
// - latch low refuses writing commands
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
module sfic_flash
  import sfic_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a,
  parameter logic [7:0] DEV_ID1 = 8'h3c,
  parameter logic [7:0] DEV_ID2 = 8'h01,
  parameter logic [7:0] LEGACY_CODE = 8'h77
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  sfic_if.flash spi,
  // neighbouring flash logic
  input wire logic busy_in,
  input wire logic latch_set,
  output logic reset_cmd_enable,
  output logic write_enable_latch,
  output logic deep_powerdown,
  output logic standby
);

  typedef enum logic [1:0] {st_standby, st_entering, st_deep, st_exiting} sfic_pwr_type;

  // id byte lookup: {valid, value}; arbitrary id values come from parameters
  function automatic logic [8:0] id_byte(input logic [7:0] op, input logic [2:0] idx);
    logic [8:0] r;
    r = 9'h000;
    if (op == OP_READ_ID_STD)
    begin
      case (idx)
        3'd1: r = {1'b1, MFR_ID};
        3'd2: r = {1'b1, DEV_ID1};
        3'd3: r = {1'b1, DEV_ID2};
        3'd4: r = {1'b1, EXT_INFO_LEN};
        default: r = 9'h000;
      endcase
    end
    else if (op == OP_READ_ID_LEGACY)
    begin
      case (idx)
        3'd1: r = {1'b1, MFR_ID};
        3'd2: r = {1'b1, LEGACY_CODE};
        default: r = 9'h000;
      endcase
    end
    return r;
  endfunction

  logic cs_prev_reg;
  logic sck_prev_reg;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [2:0] byte_reg;
  logic [2:0] byte_next;
  logic [7:0] shift_reg;
  logic [7:0] op_reg;
  logic [7:0] data_reg;
  logic miso_reg;
  logic miso_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic rce_reg;
  logic rce_next;
  logic latch_reg;
  logic latch_next;
  sfic_pwr_type state_reg;
  sfic_pwr_type state_next;
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;

  wire sel = ~spi.cs_n;
  wire sck_rise = sel & spi.sck & ~sck_prev_reg;
  wire sck_fall = sel & ~spi.sck & sck_prev_reg;
  wire cs_rise = spi.cs_n & ~cs_prev_reg;
  wire [7:0] shift_in = {shift_reg[6:0], spi.mosi};
  wire byte_done = sck_rise & (bit_reg == 3'd7);
  wire on_boundary = (bit_reg == 3'd0);
  wire op_full = (byte_reg != 3'd0);
  wire in_standby = (state_reg == st_standby);
  wire [8:0] id_now = id_byte(op_reg, byte_reg);
  wire id_drive = in_standby & id_now[8];
  wire [2:0] out_idx = 3'd7 - bit_reg;
  wire tmr_done_entry = (tmr_reg == TMR_W'(ENTRY_CYCLES - 1));
  wire tmr_done_exit = (tmr_reg == TMR_W'(EXIT_CYCLES - 1));

  // status byte two write seen at deselect with latch set
  wire wrsr2_seen = cs_rise & in_standby & ~busy_in & (op_reg == OP_WRITE_STATUS2)
                    & op_full & latch_reg;
  wire wrsr2_ok = wrsr2_seen & on_boundary & (byte_reg >= 3'd2);
  wire enter_ok = cs_rise & in_standby & ~busy_in & (op_reg == OP_DEEP_PD)
                  & op_full & on_boundary;
  wire resume_ok = cs_rise & (state_reg == st_deep) & (op_reg == OP_RESUME_PD)
                   & op_full & on_boundary;

  // bit and byte position within the frame
  always_comb
  begin
    bit_next = bit_reg;
    byte_next = byte_reg;
    if (!sel)
    begin
      bit_next = 3'd0;
      byte_next = 3'd0;
    end
    else if (sck_rise)
    begin
      bit_next = bit_reg + 3'd1;
      if (byte_done && byte_reg != 3'd7)
      begin
        byte_next = byte_reg + 3'd1;
      end
    end
  end

  // serial output, changed on falling clock
  always_comb
  begin
    miso_next = miso_reg;
    oe_n_next = oe_n_reg;
    if (!sel)
    begin
      oe_n_next = 1'b1;
    end
    else if (sck_fall)
    begin
      oe_n_next = ~id_drive;
      if (id_drive)
      begin
        miso_next = id_now[out_idx];
      end
    end
  end

  // enable bit and write latch
  always_comb
  begin
    rce_next = rce_reg;
    latch_next = latch_reg;
    if (wrsr2_ok)
    begin
      rce_next = data_reg[RESET_CMD_ENABLE_BIT];
    end
    if (wrsr2_seen)
    begin
      latch_next = 1'b0;
    end
    if (latch_set && in_standby)
    begin
      latch_next = 1'b1;
    end
  end

  // power state sequencing
  always_comb
  begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    case (state_reg)
      st_standby:
      begin
        tmr_next = '0;
        if (enter_ok)
        begin
          state_next = st_entering;
        end
      end
      st_entering:
      begin
        tmr_next = tmr_reg + TMR_W'(1);
        if (tmr_done_entry)
        begin
          state_next = st_deep;
          tmr_next = '0;
        end
      end
      st_deep:
      begin
        tmr_next = '0;
        if (resume_ok)
        begin
          state_next = st_exiting;
        end
      end
      st_exiting:
      begin
        tmr_next = tmr_reg + TMR_W'(1);
        if (tmr_done_exit)
        begin
          state_next = st_standby;
          tmr_next = '0;
        end
      end
      default:
      begin
        state_next = st_standby;
        tmr_next = '0;
      end
    endcase
  end

  // frame capture, msb first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_reg <= 8'h00;
      op_reg <= 8'h00;
      data_reg <= 8'h00;
    end
    else
    begin
      if (sck_rise)
      begin
        shift_reg <= shift_in;
      end
      if (byte_done && byte_reg == 3'd0)
      begin
        op_reg <= shift_in;
      end
      if (byte_done && byte_reg == 3'd1)
      begin
        data_reg <= shift_in;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
      bit_reg <= 3'd0;
      byte_reg <= 3'd0;
      miso_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      rce_reg <= RESET_CMD_ENABLE_RESET;
      latch_reg <= WRITE_ENABLE_LATCH_RESET;
      state_reg <= st_standby;
      tmr_reg <= '0;
    end
    else
    begin
      cs_prev_reg <= spi.cs_n;
      sck_prev_reg <= spi.sck;
      bit_reg <= bit_next;
      byte_reg <= byte_next;
      miso_reg <= miso_next;
      oe_n_reg <= oe_n_next;
      rce_reg <= rce_next;
      latch_reg <= latch_next;
      state_reg <= state_next;
      tmr_reg <= tmr_next;
    end
  end

  assign spi.miso = miso_reg;
  assign spi.miso_oe_n = oe_n_reg;
  assign reset_cmd_enable = rce_reg;
  assign write_enable_latch = latch_reg;
  assign deep_powerdown = (state_reg == st_deep);
  assign standby = in_standby & ~sel;

endmodule

// ---- sfic_host.sv ----
// host-side serial controller with apb command registers
`timescale 1ns/10ps
module sfic_host
  import sfic_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  sfic_if.host spi
);

  typedef enum logic [2:0] {h_idle, h_low, h_high, h_tail, h_gap} sfic_host_type;

  sfic_host_type state_reg;
  logic [7:0] op_reg;
  logic [7:0] dat_reg;
  logic [CMD_BITS_W-1:0] nbits_reg;
  logic [CMD_BITS_W-1:0] cnt_reg;
  logic [TX_W-1:0] tx_reg;
  logic [31:0] rx_reg;
  logic [7:0] div_reg;
  logic [7:0] tmr_reg;
  logic [31:0] prdata_reg;
  logic cs_n_reg;
  logic sck_reg;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_cmd = (paddr == HOST_CMD_OFS);
  wire hit_sts = (paddr == HOST_STATUS_OFS);
  wire hit_rx = (paddr == HOST_RXDATA_OFS);
  wire hit_div = (paddr == HOST_DIV_OFS);
  wire mapped = hit_cmd | hit_sts | hit_rx | hit_div;
  wire busy = (state_reg != h_idle);
  wire [CMD_BITS_W-1:0] wr_bits = pwdata[CMD_BITS_LSB +: CMD_BITS_W];
  wire start = access & pwrite & hit_cmd & ~busy & (wr_bits != '0);
  wire [7:0] div_eff = (div_reg < DIV_MIN) ? DIV_MIN : div_reg;
  wire tick = (tmr_reg == div_eff - 8'h01);
  wire last_bit = (cnt_reg == nbits_reg - CMD_BITS_W'(1));
  wire [31:0] cmd_view = {10'h000, nbits_reg, dat_reg, op_reg};
  wire [31:0] rd_mux = hit_cmd ? cmd_view :
                       hit_sts ? {31'h0, busy} :
                       hit_rx ? rx_reg :
                       hit_div ? {24'h0, div_reg} : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0;
      div_reg <= DIV_RESET;
    end
    else
    begin
      if (setup)
      begin
        prdata_reg <= rd_mux;
      end
      if (access && pwrite && hit_div)
      begin
        div_reg <= pwdata[7:0];
      end
    end
  end

  // frame sequencer, opcode then data byte then zero fill, msb first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= h_idle;
      op_reg <= 8'h00;
      dat_reg <= 8'h00;
      nbits_reg <= '0;
      cnt_reg <= '0;
      tx_reg <= '0;
      rx_reg <= 32'h0;
      tmr_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      sck_reg <= 1'b0;
    end
    else
    begin
      tmr_reg <= (busy && !tick) ? tmr_reg + 8'h01 : 8'h00;
      case (state_reg)
        h_idle:
        begin
          if (start)
          begin
            op_reg <= pwdata[CMD_OP_LSB +: 8];
            dat_reg <= pwdata[CMD_DATA_LSB +: 8];
            nbits_reg <= wr_bits;
            cnt_reg <= '0;
            tx_reg <= {pwdata[CMD_OP_LSB +: 8], pwdata[CMD_DATA_LSB +: 8], 24'h0};
            rx_reg <= 32'h0;
            cs_n_reg <= 1'b0;
            state_reg <= h_low;
          end
        end
        h_low:
        begin
          if (tick)
          begin
            sck_reg <= 1'b1;
            rx_reg <= {rx_reg[30:0], spi.miso_line};
            state_reg <= h_high;
          end
        end
        h_high:
        begin
          if (tick)
          begin
            sck_reg <= 1'b0;
            cnt_reg <= cnt_reg + CMD_BITS_W'(1);
            tx_reg <= {tx_reg[TX_W-2:0], 1'b0};
            state_reg <= last_bit ? h_tail : h_low;
          end
        end
        h_tail:
        begin
          if (tick)
          begin
            cs_n_reg <= 1'b1;
            state_reg <= h_gap;
          end
        end
        h_gap:
        begin
          if (tick)
          begin
            state_reg <= h_idle;
          end
        end
        default:
        begin
          state_reg <= h_idle;
        end
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign spi.cs_n = cs_n_reg;
  assign spi.sck = sck_reg;
  assign spi.mosi = tx_reg[TX_W-1];

endmodule

// ---- sfic_if.sv ----
// serial link between host controller and flash command logic
`timescale 1ns/10ps
interface sfic_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  wire miso_line;
  // released line floats high through a pull-up
  assign miso_line = miso_oe_n ? 1'b1 : miso;
  modport host (output cs_n, output sck, output mosi, input miso_line);
  modport flash (input cs_n, input sck, input mosi, output miso, output miso_oe_n);
endinterface

// ---- sfic_pkg.sv ----
// constants shared by both ends of the serial flash id / power-down link
package sfic_pkg;
  // opcodes
  localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
  localparam logic [7:0] OP_READ_ID_STD = 8'h9f;
  localparam logic [7:0] OP_READ_ID_LEGACY = 8'h15;
  localparam logic [7:0] OP_DEEP_PD = 8'hb9;
  localparam logic [7:0] OP_RESUME_PD = 8'hab;
  // second status byte layout, reset values and id read constants
  localparam int unsigned RESET_CMD_ENABLE_BIT = 4;
  localparam logic RESET_CMD_ENABLE_RESET = 1'b0;
  localparam logic WRITE_ENABLE_LATCH_RESET = 1'b0;
  localparam logic [7:0] EXT_INFO_LEN = 8'h00;
  localparam logic [2:0] STD_ID_BYTES = 3'd4;
  localparam logic [2:0] LEGACY_ID_BYTES = 3'd2;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned DEEP_SLEEP_ENTRY_TIME_NS = 3000;
  localparam int unsigned DEEP_SLEEP_EXIT_TIME_NS = 8000;
  localparam int unsigned ENTRY_CYCLES = DEEP_SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned EXIT_CYCLES = DEEP_SLEEP_EXIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 12;
  // host register map
  localparam logic [11:0] HOST_CMD_OFS = 12'h000;
  localparam logic [11:0] HOST_STATUS_OFS = 12'h004;
  localparam logic [11:0] HOST_RXDATA_OFS = 12'h008;
  localparam logic [11:0] HOST_DIV_OFS = 12'h00c;
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_DATA_LSB = 8;
  localparam int unsigned CMD_BITS_LSB = 16;
  localparam int unsigned CMD_BITS_W = 6;
  localparam logic [7:0] DIV_RESET = 8'h10;
  localparam logic [7:0] DIV_MIN = 8'h02;
  localparam int unsigned TX_W = 40;
endpackage

// ---- sfic_tb.sv ----
// self-checking bench: apb host driving the flash command logic
`timescale 1ns/10ps
module sfic_tb
  import sfic_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic busy_in = 1'b0;
  logic latch_set = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rce, latch, deep, stby, se;
  logic [31:0] rd;
  int err_total = 0;
  int checked = 0;
  int n;
  localparam logic [7:0] ID_OP [5] = '{8'h9f, 8'h9f, 8'h15, 8'h9f, 8'h15};
  localparam logic [5:0] ID_BITS [5] = '{6'd40, 6'd48, 6'd36, 6'd12, 6'd8};
  localparam logic [31:0] ID_EXP [5] = '{32'h5a3c0100, 32'h3c0100ff, 32'hf5a77fff,
    32'h00000ff5, 32'h000000ff};
  always #2 pclk = ~pclk;
  sfic_if sfic_if_i();
  sfic_host sfic_host_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi(sfic_if_i));
  sfic_flash sfic_flash_i(.pclk(pclk), .presetn(presetn), .spi(sfic_if_i), .busy_in(busy_in),
    .latch_set(latch_set), .reset_cmd_enable(rce), .write_enable_latch(latch),
    .deep_powerdown(deep), .standby(stby));
  sfic_assertions sfic_assertions_i(.pclk(pclk), .presetn(presetn), .cs_n(sfic_if_i.cs_n),
    .sck(sfic_if_i.sck), .miso_oe_n(sfic_if_i.miso_oe_n), .reset_cmd_enable(rce),
    .write_enable_latch(latch), .deep_powerdown(deep), .standby(stby));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task frame(input logic [7:0] op, input logic [7:0] d, input logic [5:0] bits);
    apb(1'b1, HOST_CMD_OFS, {10'h000, bits, d, op});
    for (n = 0; n < 3000; n++)
    begin
      apb(1'b0, HOST_STATUS_OFS, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
  endtask
  task rx_chk(input logic [31:0] exp);
    apb(1'b0, HOST_RXDATA_OFS, 32'h0);
    chk(rd, exp);
  endtask
  task latch_pulse;
    @(posedge pclk);
    latch_set <= 1'b1;
    @(posedge pclk);
    latch_set <= 1'b0;
    @(posedge pclk);
  endtask
  task test_done;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge pclk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({28'h0, rce, latch, deep, stby}, 32'h1);
    apb(1'b0, HOST_DIV_OFS, 32'h0);
    chk(rd, {24'h0, DIV_RESET});
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], se}, 32'h1);
    $display("test reset done");
    frame(OP_WRITE_STATUS2, 8'h10, 6'd16);
    chk({30'h0, rce, latch}, 32'h0);
    latch_pulse;
    frame(OP_WRITE_STATUS2, 8'h10, 6'd24);
    chk({30'h0, rce, latch}, 32'h2);
    latch_pulse;
    frame(OP_WRITE_STATUS2, 8'hef, 6'd12);
    chk({30'h0, rce, latch}, 32'h2);
    latch_pulse;
    frame(OP_WRITE_STATUS2, 8'hef, 6'd7);
    chk({30'h0, rce, latch}, 32'h3);
    frame(OP_WRITE_STATUS2, 8'hef, 6'd16);
    chk({30'h0, rce, latch}, 32'h0);
    $display("test status write done");
    for (int i = 0; i < 5; i++)
    begin
      frame(ID_OP[i], 8'h00, ID_BITS[i]);
      rx_chk(ID_EXP[i]);
    end
    $display("test id reads done");
    apb(1'b1, HOST_DIV_OFS, {24'h0, DIV_MIN});
    frame(OP_DEEP_PD, 8'h00, 6'd12);
    frame(OP_DEEP_PD, 8'h00, 6'd7);
    busy_in <= 1'b1;
    frame(OP_DEEP_PD, 8'h00, 6'd8);
    busy_in <= 1'b0;
    repeat (760) @(posedge pclk);
    chk({30'h0, deep, stby}, 32'h1);
    frame(OP_DEEP_PD, 8'h00, 6'd16);
    repeat (760) @(posedge pclk);
    chk({30'h0, deep, stby}, 32'h2);
    latch_pulse;
    chk({31'h0, latch}, 32'h0);
    frame(OP_READ_ID_STD, 8'h00, 6'd40);
    rx_chk(32'hffffffff);
    frame(OP_RESUME_PD, 8'h00, 6'd12);
    repeat (2010) @(posedge pclk);
    chk({30'h0, deep, stby}, 32'h2);
    frame(OP_RESUME_PD, 8'h00, 6'd8);
    repeat (2010) @(posedge pclk);
    chk({30'h0, deep, stby}, 32'h1);
    frame(OP_READ_ID_STD, 8'h00, 6'd40);
    rx_chk(32'h5a3c0100);
    $display("test deep power-down done");
    test_done;
  end
endmodule
